// [hdl/temp_alert_and_serial_reset.v]
// Alert comparison logic and serial port framing with long-ones recovery
`include "temp_alert_map.vh"

module temp_alert_and_serial_reset (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        serial_data_in,
  output reg         serial_data_out,
  output wire        serial_data_out_oe,
  input  wire [15:0] tx_word,
  output reg  [7:0]  rx_byte,
  output reg         rx_byte_valid,
  output reg         rx_is_command,
  output reg         iface_reset,
  output wire        expect_command,
  input  wire        wr_high,
  input  wire        wr_low,
  input  wire        wr_hyst,
  input  wire        wr_mode,
  input  wire [15:0] wr_data,
  input  wire        reg_read,
  input  wire        shutdown,
  input  wire        temp_valid,
  input  wire [15:0] temp_value,
  output reg  [15:0] high_limit,
  output reg  [15:0] low_limit,
  output reg  [3:0]  hysteresis_value,
  output reg         alert_mode,
  output wire        alert_out
);

  localparam ST_COMMAND = 1'b0;
  localparam ST_DATA    = 1'b1;

  reg        rst_meta;
  reg        rst_sync;
  wire       rst_n_int = rst_sync;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Pins: three-stage sync, change accepted when stages two and three agree
  wire [2:0] pin_raw = {serial_data_in, cs_n, sclk};
  wire [2:0] pin_filt;
  reg  [2:0] pin_prev;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      reg s1;
      reg s2;
      reg s3;
      reg filt;
      always @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
          s1   <= 1'b1;
          s2   <= 1'b1;
          s3   <= 1'b1;
          filt <= 1'b1;
        end else begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            filt <= s3;
          end
        end
      end
      assign pin_filt[g] = filt;
    end
  endgenerate

  always @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pin_prev <= 3'h7;
    end else begin
      pin_prev <= pin_filt;
    end
  end

  wire sclk_rise = pin_filt[0] & ~pin_prev[0];
  wire sclk_fall = ~pin_filt[0] & pin_prev[0];
  wire cs_low    = ~pin_filt[1];
  wire cs_fall   = ~pin_filt[1] & pin_prev[1];
  wire din       = pin_filt[2];

  // Serial framing
  reg       state;
  reg [3:0] bit_count;
  reg [7:0] shift_in;
  reg [15:0] shift_out;
  reg [5:0] ones_count;
  wire      ones_hit = sclk_rise & din & (ones_count == `ONES_FOR_RESET - 6'h01);

  assign expect_command     = (state == ST_COMMAND);
  assign serial_data_out_oe = cs_low;

  always @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ones_count  <= 6'h00;
      iface_reset <= 1'b0;
    end else begin
      iface_reset <= ones_hit;
      // Counts sclk edges only, so a clock idling between frames adds nothing
      if (sclk_rise) begin
        if (!din) begin
          ones_count <= 6'h00;
        end else if (ones_count != `ONES_FOR_RESET) begin
          ones_count <= ones_count + 6'h01;
        end
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state           <= ST_COMMAND;
      bit_count       <= 4'h0;
      shift_in        <= 8'h00;
      shift_out       <= 16'h0000;
      serial_data_out <= 1'b0;
      rx_byte         <= 8'h00;
      rx_byte_valid   <= 1'b0;
      rx_is_command   <= 1'b0;
    end else begin
      rx_byte_valid <= 1'b0;
      if (ones_hit) begin
        state     <= ST_COMMAND;
        bit_count <= 4'h0;
      end else if (!cs_low) begin
        state     <= ST_COMMAND;
        bit_count <= 4'h0;
      end else begin
        // Frame-sync use: the first bit appears on the select edge itself
        if (cs_fall) begin
          serial_data_out <= tx_word[15];
          shift_out       <= {tx_word[14:0], 1'b0};
        end else if (sclk_fall) begin
          serial_data_out <= shift_out[15];
          shift_out       <= {shift_out[14:0], 1'b0};
        end
        // Cs tied low still works: bytes keep counting with no frame edge
        if (sclk_rise) begin
          shift_in <= {shift_in[6:0], din};
          if (bit_count == `CMD_BITS - 4'h1) begin
            bit_count     <= 4'h0;
            rx_byte       <= {shift_in[6:0], din};
            rx_byte_valid <= 1'b1;
            rx_is_command <= (state == ST_COMMAND);
            case (state)
              ST_COMMAND: state <= ST_DATA;
              ST_DATA:    state <= ST_DATA;
              default:    state <= ST_COMMAND;
            endcase
          end else begin
            bit_count <= bit_count + 4'h1;
          end
        end
      end
    end
  end

  // Settings, returned to power-on values by the long-ones reset
  always @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      high_limit       <= `HIGH_LIMIT_RESET;
      low_limit        <= `LOW_LIMIT_RESET;
      hysteresis_value <= `HYST_RESET;
      alert_mode       <= `MODE_RESET;
    end else if (ones_hit) begin
      high_limit       <= `HIGH_LIMIT_RESET;
      low_limit        <= `LOW_LIMIT_RESET;
      hysteresis_value <= `HYST_RESET;
      alert_mode       <= `MODE_RESET;
    end else begin
      if (wr_high) begin
        high_limit <= wr_data;
      end
      if (wr_low) begin
        low_limit <= wr_data;
      end
      if (wr_hyst) begin
        hysteresis_value <= wr_data[3:0];
      end
      if (wr_mode) begin
        alert_mode <= wr_data[0];
      end
    end
  end

  // Limit comparisons at 17 bits so limit +/- hysteresis cannot wrap
  wire signed [16:0] t_s    = {temp_value[15], temp_value};
  wire signed [16:0] hi_s   = {high_limit[15], high_limit};
  wire signed [16:0] lo_s   = {low_limit[15], low_limit};
  wire signed [16:0] hyst_s = $signed({6'h00, hysteresis_value, 7'h00});
  wire signed [16:0] hi_rel = hi_s - hyst_s;
  wire signed [16:0] lo_rel = lo_s + hyst_s;
  wire over    = t_s > hi_s;
  wire under   = t_s < lo_s;
  wire below_h = t_s < hi_rel;
  wire above_l = t_s > lo_rel;

  reg alert_hi;
  reg alert_lo;
  reg hi_armed;
  reg lo_armed;
  reg shutdown_prev;
  wire shutdown_rise = shutdown & ~shutdown_prev;
  wire comp_mode     = (alert_mode == `MODE_COMPARATOR);
  wire clr_int       = ~comp_mode & (reg_read | shutdown_rise | ones_hit);
  wire new_hi        = temp_valid & over & (comp_mode | hi_armed);
  wire new_lo        = temp_valid & under & (comp_mode | lo_armed);

  assign alert_out = alert_hi | alert_lo;

  always @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      alert_hi      <= 1'b0;
      alert_lo      <= 1'b0;
      hi_armed      <= 1'b1;
      lo_armed      <= 1'b1;
      shutdown_prev <= 1'b0;
    end else begin
      shutdown_prev <= shutdown;
      // A fresh crossing in the clearing cycle wins over the clear
      if (new_hi) begin
        alert_hi <= 1'b1;
      end else if (comp_mode & temp_valid & below_h) begin
        alert_hi <= 1'b0;
      end else if (clr_int | (comp_mode & ones_hit)) begin
        alert_hi <= 1'b0;
      end
      if (new_lo) begin
        alert_lo <= 1'b1;
      end else if (comp_mode & temp_valid & above_l) begin
        alert_lo <= 1'b0;
      end else if (clr_int | (comp_mode & ones_hit)) begin
        alert_lo <= 1'b0;
      end
      // Comparator shutdown is not a clear term at all
      // Interrupt rearm needs a reading below high minus hysteresis, or above low plus hysteresis
      if (new_hi & ~comp_mode) begin
        hi_armed <= 1'b0;
      end else if (temp_valid & below_h) begin
        hi_armed <= 1'b1;
      end
      if (new_lo & ~comp_mode) begin
        lo_armed <= 1'b0;
      end else if (temp_valid & above_l) begin
        lo_armed <= 1'b1;
      end
    end
  end

endmodule

// [hdl/temp_alert_map.vh]
// Constants for the temperature alert and serial reset block
// Notes on behaviour
// - Low chip select frames each transfer, including DSP frame-sync use.
// - Chip select falling presents the output word's most significant bit at once.
// - A serial clock running between frames is harmless.
// - Chip select tied low gives a working 3-wire input; the output word is loaded only on a chip select fall.
// - Input held high for 32 serial clocks resets the serial interface.
// - After that reset the next byte is taken as a command byte.
// - That reset also returns every register to its power-on value.
// - Comparator and interrupt alert behaviours; interrupt is the power-up choice.
// - Alert asserts when temperature is above high limit or below low limit.
// - Comparator: alert drops below high minus hysteresis or above low plus hysteresis.
// - Comparator: shutdown leaves the alert state as it is.
// - Interrupt: any register read clears the alert.
// - Interrupt: after clearing, alert returns only on a fresh limit crossing.
// - Interrupt: entering shutdown clears the alert.
// - Hysteresis is unsigned 4 bits, whole degrees 0 to 15.
// - Limits and temperature compare as signed twos-complement numbers.
`ifndef TEMP_ALERT_MAP_VH
`define TEMP_ALERT_MAP_VH

`define HIGH_LIMIT_RESET   16'h2000
`define LOW_LIMIT_RESET    16'h0500
`define HYST_RESET         4'h5
`define MODE_RESET         1'b0
`define MODE_INTERRUPT     1'b0
`define MODE_COMPARATOR    1'b1
`define HYST_SHIFT         7
`define ONES_FOR_RESET     6'h20
`define CMD_BITS           4'h8
`define WORD_BITS          5'h10

`endif

// [tb/temp_alert_monitor.sv]
// Property checker for the alert logic and serial recovery
module temp_alert_monitor (
  input logic        ref_clk,
  input logic        rstn,
  input logic        temp_valid,
  input logic [15:0] temp_value,
  input logic [15:0] high_limit,
  input logic [15:0] low_limit,
  input logic [3:0]  hysteresis_value,
  input logic        alert_mode,
  input logic        alert_out,
  input logic        reg_read,
  input logic        shutdown,
  input logic        iface_reset,
  input logic        expect_command
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_DEFAULTS: assert property (iface_reset |-> high_limit == 16'h2000 &&
    low_limit == 16'h0500 && hysteresis_value == 4'h5 && !alert_mode) else $error("defaults");
  AST_CMD_IDLE: assert property (iface_reset |-> expect_command)
    else $error("no command state");
  AST_CMP_HIGH: assert property (alert_mode && temp_valid &&
    $signed(temp_value) > $signed(high_limit) |=> alert_out) else $error("high miss");
  AST_CMP_LOW: assert property (alert_mode && temp_valid &&
    $signed(temp_value) < $signed(low_limit) |=> alert_out) else $error("low miss");
  AST_INT_READ: assert property (!alert_mode && reg_read && !temp_valid |=>
    !alert_out) else $error("read kept alert");
  AST_INT_SHDN: assert property (!alert_mode && $rose(shutdown) && !temp_valid |=>
    !alert_out) else $error("shutdown kept alert");
  AST_CMP_HOLD: assert property (alert_mode && !temp_valid |=>
    alert_out == $past(alert_out) || iface_reset) else $error("alert moved");
  AST_NO_SPONT: assert property (!alert_out && !temp_valid |=> !alert_out)
    else $error("alert without sample");
endmodule
bind temp_alert_and_serial_reset temp_alert_monitor mon (.*);

// [tb/spi_host_model.sv]
// Behavioural serial host: framed transfers and long-ones recovery
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic serial_data_in,
  input  logic serial_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Select falls with the clock low, so the first bit leaves on the select edge
  task automatic xfer(input logic [15:0] d, output logic [15:0] q);
    sclk = 1'b0;
    #62.5 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_data_in = d[i];
      #62.5 sclk = 1'b1;
      q[i] = serial_data_out;
      #62.5 sclk = 1'b0;
    end
    cs_n = 1'b1;
    serial_data_in = ~d[0];
    #62.5 sclk = 1'b1;
  endtask
  // Select held low over four bytes, as with a tied-low select
  task automatic xfer3(input logic [31:0] d);
    sclk = 1'b0;
    #62.5 cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      serial_data_in = d[i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    cs_n = 1'b1;
    serial_data_in = 1'b0;
    #62.5 sclk = 1'b1;
  endtask
  // Clock runs with select high; a leading zero restarts the count
  task automatic ones(input int n);
    for (int i = 0; i <= n; i++) begin
      #62.5 sclk = 1'b0;
      serial_data_in = (i != 0);
      #62.5 sclk = 1'b1;
    end
    #62.5 serial_data_in = 1'b0;
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for alert logic and serial framing
`define CHK(n, g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, sclk, cs_n, serial_data_in, serial_data_out, serial_data_out_oe;
  logic rx_byte_valid, rx_is_command, iface_reset, expect_command, alert_mode, alert_out;
  logic wr_high, wr_low, wr_hyst, wr_mode, reg_read, shutdown, temp_valid, seen;
  logic [15:0] tx_word, wr_data, temp_value, high_limit, low_limit, q;
  logic [7:0]  rx_byte, cmd_byte;
  logic [3:0]  hysteresis_value;
  int          errors, samples_checked, rx_count;
  temp_alert_and_serial_reset dut (.*);
  // Undriven output pin shows the inverse, so a late enable corrupts the read
  spi_host_model host (.sclk, .cs_n, .serial_data_in,
    .serial_data_out(serial_data_out_oe ? serial_data_out : ~serial_data_out));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (iface_reset === 1'b1) seen <= 1'b1;
  always @(posedge ref_clk) begin
    if (rx_byte_valid === 1'b1) begin
      rx_count <= rx_count + 1;
      if (rx_is_command === 1'b1) cmd_byte <= rx_byte;
    end
  end
  task automatic test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] k, input logic [15:0] d);
    @(posedge ref_clk);
    {wr_mode, wr_hyst, wr_low, wr_high} <= k;
    wr_data <= d;
    @(posedge ref_clk);
    {wr_mode, wr_hyst, wr_low, wr_high} <= 4'h0;
  endtask
  task automatic step(input logic v, input logic [15:0] t, input logic [1:0] k, input logic e);
    @(posedge ref_clk);
    temp_valid <= v;
    temp_value <= t;
    {shutdown, reg_read} <= k;
    @(posedge ref_clk);
    temp_valid <= 1'b0;
    reg_read <= 1'b0;
    @(posedge ref_clk);
    #1 `CHK("alert_out", alert_out, e)
  endtask
  task automatic t_frame;
    host.xfer(16'h3C96, q);
    `CHK("serial_data_out", q, 16'hA5C3)
    `CHK("rx_byte", rx_byte, 8'h96)
    `CHK("rx_is_command", rx_is_command, 1'b0)
    `CHK("rx_count", rx_count, 2)
    `CHK("cmd_byte", cmd_byte, 8'h3C)
    `CHK("serial_data_out_oe", serial_data_out_oe, 1'b0)
    `CHK("alert_mode", alert_mode, 1'b0)
  endtask
  task automatic t_three_wire;
    host.xfer3(32'h1A2B3C4D);
    `CHK("rx_count", rx_count, 6)
    `CHK("cmd_byte", cmd_byte, 8'h1A)
    `CHK("rx_byte", rx_byte, 8'h4D)
    `CHK("rx_is_command", rx_is_command, 1'b0)
  endtask
  task automatic t_serial_reset;
    wr(4'h1, 16'h1234);
    wr(4'h2, 16'h0100);
    wr(4'h4, 16'h0003);
    wr(4'h8, 16'h0001);
    `CHK("high_limit written", high_limit, 16'h1234)
    `CHK("hysteresis_value written", hysteresis_value, 4'h3)
    host.ones(31);
    `CHK("early iface_reset", seen, 1'b0)
    host.ones(32);
    `CHK("iface_reset", seen, 1'b1)
    `CHK("high_limit", high_limit, 16'h2000)
    `CHK("hysteresis_value", hysteresis_value, 4'h5)
    `CHK("low_limit", low_limit, 16'h0500)
    `CHK("alert_mode after reset", alert_mode, 1'b0)
    `CHK("expect_command", expect_command, 1'b1)
    repeat (50000) @(posedge ref_clk);
  endtask
  task automatic t_comparator;
    wr(4'h8, 16'h0001);
    step(1'b1, 16'h2001, 2'h0, 1'b1);
    step(1'b1, 16'h1E00, 2'h0, 1'b1);
    step(1'b0, 16'h0000, 2'h2, 1'b1);
    step(1'b1, 16'h1D7F, 2'h0, 1'b0);
    step(1'b1, 16'hFF00, 2'h0, 1'b1);
    step(1'b1, 16'h0780, 2'h0, 1'b1);
    step(1'b1, 16'h0781, 2'h0, 1'b0);
  endtask
  task automatic t_interrupt;
    wr(4'h8, 16'h0000);
    step(1'b1, 16'h1000, 2'h1, 1'b0);
    step(1'b1, 16'h2100, 2'h0, 1'b1);
    step(1'b0, 16'h0000, 2'h1, 1'b0);
    step(1'b1, 16'h2100, 2'h0, 1'b0);
    step(1'b1, 16'h1000, 2'h0, 1'b0);
    step(1'b1, 16'h2100, 2'h0, 1'b1);
    step(1'b0, 16'h0000, 2'h2, 1'b0);
  endtask
  initial begin
    #1ms;
    errors++;
    test_done;
  end
  initial begin
    rstn = 1'b0;
    {wr_high, wr_low, wr_hyst, wr_mode, reg_read, shutdown, temp_valid, seen} = 8'h00;
    {wr_data, temp_value} = 32'h0;
    tx_word = 16'hA5C3;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_frame;
    t_three_wire;
    t_serial_reset;
    t_comparator;
    t_interrupt;
    test_done;
  end
endmodule
